// ==== scsi_cfg_pkg.sv ====
// Shared constants, types and helpers for the adapter query command block.
package scsi_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map and field positions
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_DATA_IN = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_CONFIG = 3'h3;
  localparam logic [2:0] REG_CTRL = 3'h4;
  localparam logic [2:0] REG_TMODE = 3'h5;
  localparam logic [2:0] REG_TMASK = 3'h6;
  localparam logic [2:0] REG_OPTION = 3'h7;
  localparam int ST_COMPLETE = 0;
  localparam int ST_INVALID = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_DATA = 3;
  localparam int CTRL_CLR_COMPLETE = 0;
  localparam int CTRL_CLR_INVALID = 1;
  localparam int CTRL_SOFT_RST = 2;
  localparam int CFG_ID_LSB = 0;
  localparam int CFG_IRQ_LSB = 3;
  localparam int CFG_DMA_LSB = 6;
  localparam int OPT_TM_FEATURE = 0;
  localparam logic [7:0] CONFIG_RST = 8'h07;
  localparam logic [7:0] OPTION_RST = 8'h01;

  // ----------------------------------------------------------------
  // Commands, selectors and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SCAN = 8'h0A;
  localparam logic [7:0] OP_CONFIG = 8'h0B;
  localparam logic [7:0] OP_TMODE = 8'h0C;
  localparam logic [7:0] SEL_INITIATOR = 8'h00;
  localparam logic [7:0] SEL_TARGET = 8'h01;
  localparam logic [3:0] SCAN_BYTES = 4'h8;
  localparam logic [3:0] CFG_BYTES = 4'h3;
  localparam logic [2:0] LAST_ID = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int RETRY_MS = 250;
  localparam int LIMIT_MS = 60000;
  localparam int RETRY_CYC = RETRY_MS * 1000 * CLK_MHZ;
  localparam int MAX_RETRY = LIMIT_MS / RETRY_MS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SCAN_ISSUE = 3'h1,
    ST_SCAN_WAIT = 3'h3,
    ST_SCAN_RETRY = 3'h2,
    ST_REPLY = 3'h6,
    ST_PARM0 = 3'h4,
    ST_PARM1 = 3'h5
  } state_e;

  typedef struct packed {
    logic [2:0] tgt;
    logic [2:0] lun;
  } probe_req_s;

  typedef struct packed {
    logic done;
    logic present;
    logic busy;
  } probe_rsp_s;

  function automatic logic [7:0] lun_bit(input logic [2:0] k);
    lun_bit = 8'h01 << k;
  endfunction

  function automatic logic [7:0] dma_code(input logic [1:0] sel);
    case (sel)
      2'h0: dma_code = 8'h01;
      2'h1: dma_code = 8'h20;
      2'h2: dma_code = 8'h40;
      default: dma_code = 8'h80;
    endcase
  endfunction

  function automatic logic [7:0] irq_code(input logic [2:0] sel);
    case (sel)
      3'h0: irq_code = 8'h01;
      3'h1: irq_code = 8'h02;
      3'h2: irq_code = 8'h04;
      3'h3: irq_code = 8'h08;
      3'h4: irq_code = 8'h20;
      default: irq_code = 8'h40;
    endcase
  endfunction

endpackage

// ==== reply_buffer.sv ====
// Small byte store that holds a command reply and hands it out in order.
`timescale 1ns/100ps
module reply_buffer #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [AW-1:0] i_widx,
  input wire logic [7:0] i_wdata,
  input wire logic i_load,
  input wire logic [AW:0] i_len,
  input wire logic i_pop,
  output logic [7:0] o_head,
  output logic [AW:0] o_left
);
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] rd_reg;
  logic [AW:0] left_reg;

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_widx] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rd_reg <= '0;
      left_reg <= '0;
    end else if (i_load) begin
      rd_reg <= '0;
      left_reg <= i_len;
    end else if (i_pop && left_reg != '0) begin
      rd_reg <= rd_reg + AW'(1);
      left_reg <= left_reg - (AW+1)'(1);
    end
  end

  assign o_head = mem[rd_reg];
  assign o_left = left_reg;
endmodule

// ==== retry_timer.sv ====
// Interval timer that pulses once a fixed number of cycles after a start.
`timescale 1ns/100ps
module retry_timer #(
  parameter int CYC = 25000000,
  parameter int CW = $clog2(CYC + 1)
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_start,
  output logic o_expire
);
  logic [CW-1:0] cnt_reg;
  logic expire_reg;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_reg <= '0;
      expire_reg <= 1'b0;
    end else begin
      expire_reg <= (cnt_reg == CW'(1)) && !i_start;
      if (i_start) begin
        cnt_reg <= CW'(CYC);
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - CW'(1);
      end
    end
  end

  assign o_expire = expire_reg;
endmodule

// ==== scsi_cfg_cmd.sv ====
// Command handler for the device scan, configuration query and target mode.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/100ps

// How it works
// (R1) Scan sends Test Unit Ready to each target and LUN, returns eight bytes; the adapter's own ID is not probed.
// (R2) Scan byte n is target n; bit k set means LUN k installed.
// (R3) Busy target is retried every 250 ms for at most one minute.
// (R4) The scan byte at the adapter's own ID is always zero.
// (R5) After all eight scan bytes are read, command complete is raised.
// (R6) Config query returns DMA, interrupt, ID bytes; DMA uses bits 7,6,5,0.
// (R7) Interrupt byte one-hot in bits 0-3,5,6; ID byte holds ID in 2-0.
// (R8) After the three config bytes are read, command complete is raised.
// (R9) Host sends a mode selector and a LUN mask after target mode opcode.
// (R10) Selector 00h initiator only, 01h adds target; others are invalid.
// (R11) LUN mask bit k set makes LUN k installed in target mode.
// (R12) Host gives at least one mask bit when enabling target mode.
// (R13) Disabling target mode ignores the LUN mask byte.
// (R14) Target mode command is invalid when the feature is switched off.
// (R15) Leaving target mode with target blocks still active is invalid.
// (R16) Inquiry answer reports whether the addressed LUN is installed.
// (R17) With target mode off the adapter never answers a selection.
// (R18) Hard, soft and power-on reset all disable target mode.
// (R19) A SCSI bus reset keeps the target mode state as it was.
// (R20) Invalid commands set their own flag, apart from command complete.
// (R21) A valid target mode command raises complete after it takes effect.
// (R22) Reply bytes leave the data-in register lowest byte first.
module scsi_cfg_cmd #(
  parameter int RETRY_CYC = scsi_cfg_pkg::RETRY_CYC,
  parameter logic [7:0] MAX_RETRY = 8'(scsi_cfg_pkg::MAX_RETRY)
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [scsi_cfg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [scsi_cfg_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [scsi_cfg_pkg::DATA_W-1:0] o_rdata,
  output logic o_probe_req,
  output scsi_cfg_pkg::probe_req_s o_probe,
  input scsi_cfg_pkg::probe_rsp_s i_probe,
  input wire logic i_tm_ccb_active,
  input wire logic [2:0] i_inq_lun,
  output logic o_inq_installed,
  output logic o_sel_respond,
  output logic o_command_complete_flag,
  output logic o_invalid_command_flag
);
  import scsi_cfg_pkg::*;

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  state_e state_reg, state_next;
  probe_req_s probe_reg, probe_next;
  logic probe_req_reg, probe_req_next;
  logic [7:0] scan_byte_reg, scan_byte_next;
  logic [7:0] retry_reg, retry_next;
  logic [7:0] parm0_reg, parm0_next;
  logic tm_mode_reg, tm_mode_next;
  logic [7:0] tm_mask_reg, tm_mask_next;
  logic [7:0] config_reg;
  logic [7:0] option_reg;
  logic [7:0] rdata_reg, rdata_next;
  logic complete_reg, invalid_reg;
  logic inq_reg, sel_reg;
  logic set_complete, set_invalid;
  logic buf_we, buf_load, timer_start, timer_expire;
  logic [2:0] buf_widx;
  logic [7:0] buf_wdata;
  logic [3:0] buf_len;
  logic [7:0] buf_head;
  logic [3:0] buf_left;
  logic [7:0] status_word;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_cmd = i_wr && (i_addr == REG_CMD);
  wire rd_data = i_rd && (i_addr == REG_DATA_IN);
  wire wr_config = i_wr && (i_addr == REG_CONFIG);
  wire wr_ctrl = i_wr && (i_addr == REG_CTRL);
  wire wr_option = i_wr && (i_addr == REG_OPTION);
  wire soft_rst = wr_ctrl && i_wdata[CTRL_SOFT_RST];
  wire clr_complete = wr_ctrl && i_wdata[CTRL_CLR_COMPLETE];
  wire clr_invalid = wr_ctrl && i_wdata[CTRL_CLR_INVALID];
  wire any_rst = i_rst || soft_rst;
  wire [2:0] own_id = config_reg[CFG_ID_LSB +: 3];
  wire [2:0] irq_sel = config_reg[CFG_IRQ_LSB +: 3];
  wire [1:0] dma_sel = config_reg[CFG_DMA_LSB +: 2];
  wire tm_feature = option_reg[OPT_TM_FEATURE];
  wire own_hit = (probe_reg.tgt == own_id);
  wire last_tgt = (probe_reg.tgt == LAST_ID);
  wire last_lun = (probe_reg.lun == LAST_ID);
  wire lun_found = i_probe.present && !i_probe.busy;
  wire may_retry = i_probe.busy && (retry_reg < MAX_RETRY);
  wire last_pop = rd_data && (buf_left == 4'h1);

  // ----------------------------------------------------------------
  // Reply store and retry timer
  // ----------------------------------------------------------------
  reply_buffer #(.DEPTH(8), .AW(3)) u_reply (
    .i_mclk(i_mclk),
    .i_rst(any_rst),
    .i_we(buf_we),
    .i_widx(buf_widx),
    .i_wdata(buf_wdata),
    .i_load(buf_load),
    .i_len(buf_len),
    .i_pop(rd_data),
    .o_head(buf_head),
    .o_left(buf_left)
  );

  retry_timer #(.CYC(RETRY_CYC)) u_retry (
    .i_mclk(i_mclk),
    .i_rst(any_rst),
    .i_start(timer_start),
    .o_expire(timer_expire)
  );

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    probe_next = probe_reg;
    probe_req_next = 1'b0;
    scan_byte_next = scan_byte_reg;
    retry_next = retry_reg;
    parm0_next = parm0_reg;
    tm_mode_next = tm_mode_reg;
    tm_mask_next = tm_mask_reg;
    set_complete = 1'b0;
    set_invalid = 1'b0;
    buf_we = 1'b0;
    buf_widx = probe_reg.tgt;
    buf_wdata = 8'h00;
    buf_load = 1'b0;
    buf_len = SCAN_BYTES;
    timer_start = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (wr_cmd) begin
          case (i_wdata)
            OP_SCAN: begin
              probe_next = '0;
              scan_byte_next = 8'h00;
              retry_next = 8'h00;
              state_next = ST_SCAN_ISSUE;
            end
            OP_CONFIG: begin
              buf_we = 1'b1; // [R6] [R7]
              buf_widx = 3'h0;
              buf_wdata = dma_code(dma_sel);
              buf_load = 1'b1;
              buf_len = CFG_BYTES;
              state_next = ST_REPLY;
            end
            OP_TMODE: state_next = ST_PARM0; // [R9]
            default: set_invalid = 1'b1; // [R20]
          endcase
        end
      end
      ST_SCAN_ISSUE: begin
        if (own_hit) begin
          buf_we = 1'b1; // [R4]
          buf_wdata = 8'h00;
          probe_next.lun = 3'h0;
          if (last_tgt) begin
            buf_load = 1'b1;
            state_next = ST_REPLY;
          end else begin
            probe_next.tgt = probe_reg.tgt + 3'h1;
          end
        end else begin
          probe_req_next = 1'b1; // [R1]
          state_next = ST_SCAN_WAIT;
        end
      end
      ST_SCAN_WAIT: begin
        if (i_probe.done) begin
          if (may_retry) begin
            retry_next = retry_reg + 8'h01; // [R3]
            timer_start = 1'b1;
            state_next = ST_SCAN_RETRY;
          end else begin
            retry_next = 8'h00;
            if (lun_found) begin
              scan_byte_next = scan_byte_reg | lun_bit(probe_reg.lun); // [R2]
            end
            state_next = ST_SCAN_ISSUE;
            if (last_lun) begin
              buf_we = 1'b1; // [R1]
              buf_wdata = scan_byte_next;
              scan_byte_next = 8'h00;
              probe_next.lun = 3'h0;
              if (last_tgt) begin
                buf_load = 1'b1;
                state_next = ST_REPLY;
              end else begin
                probe_next.tgt = probe_reg.tgt + 3'h1;
              end
            end else begin
              probe_next.lun = probe_reg.lun + 3'h1;
            end
          end
        end
      end
      ST_SCAN_RETRY: begin
        if (timer_expire) begin
          state_next = ST_SCAN_ISSUE; // [R3]
        end
      end
      ST_REPLY: begin
        if (buf_left == CFG_BYTES && !buf_load) begin
          buf_we = 1'b0;
        end
        if (last_pop) begin
          set_complete = 1'b1; // [R5] [R8]
          state_next = ST_IDLE;
        end
      end
      ST_PARM0: begin
        if (wr_cmd) begin
          parm0_next = i_wdata;
          state_next = ST_PARM1;
        end
      end
      ST_PARM1: begin
        if (wr_cmd) begin
          state_next = ST_IDLE;
          if (!tm_feature) begin
            set_invalid = 1'b1; // [R14]
          end else if (parm0_reg == SEL_INITIATOR) begin
            if (tm_mode_reg && i_tm_ccb_active) begin
              set_invalid = 1'b1; // [R15]
            end else begin
              tm_mode_next = 1'b0; // [R13] [R10]
              set_complete = 1'b1; // [R21]
            end
          end else if (parm0_reg == SEL_TARGET) begin
            tm_mode_next = 1'b1; // [R10]
            tm_mask_next = i_wdata; // [R11] [R12]
            set_complete = 1'b1; // [R21]
          end else begin
            set_invalid = 1'b1; // [R10] [R20]
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Config reply bytes one and two are decoded live from config_reg at read time, behind byte zero
  // ----------------------------------------------------------------
  logic cfg_fill_reg;
  always_ff @(posedge i_mclk) begin
    if (any_rst) begin
      cfg_fill_reg <= 1'b0;
    end else begin
      cfg_fill_reg <= (state_reg == ST_IDLE) && wr_cmd && i_wdata == OP_CONFIG;
    end
  end
  logic [7:0] cfg_mem1, cfg_mem2;
  assign cfg_mem1 = irq_code(irq_sel); // [R7]
  assign cfg_mem2 = {5'h00, own_id}; // [R7]

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (any_rst) begin
      state_reg <= ST_IDLE;
      probe_reg <= '0;
      probe_req_reg <= 1'b0;
      scan_byte_reg <= 8'h00;
      retry_reg <= 8'h00;
      parm0_reg <= 8'h00;
      tm_mode_reg <= 1'b0; // [R18] [R19]
      tm_mask_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      probe_reg <= probe_next;
      probe_req_reg <= probe_req_next;
      scan_byte_reg <= scan_byte_next;
      retry_reg <= retry_next;
      parm0_reg <= parm0_next;
      tm_mode_reg <= tm_mode_next;
      tm_mask_reg <= tm_mask_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      config_reg <= CONFIG_RST;
      option_reg <= OPTION_RST;
    end else begin
      if (wr_config) begin
        config_reg <= i_wdata;
      end
      if (wr_option) begin
        option_reg <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (any_rst) begin
      complete_reg <= 1'b0;
      invalid_reg <= 1'b0;
      inq_reg <= 1'b0;
      sel_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      complete_reg <= set_complete || (complete_reg && !clr_complete);
      invalid_reg <= set_invalid || (invalid_reg && !clr_invalid); // [R20]
      inq_reg <= tm_mode_reg && tm_mask_reg[i_inq_lun]; // [R16]
      sel_reg <= tm_mode_reg; // [R17]
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    status_word = 8'h00;
    status_word[ST_COMPLETE] = complete_reg;
    status_word[ST_INVALID] = invalid_reg;
    status_word[ST_BUSY] = (state_reg != ST_IDLE);
    status_word[ST_DATA] = (state_reg == ST_REPLY) && (buf_left != 4'h0);
  end

  logic cfg_view_reg;
  wire cfg_view = cfg_view_reg;
  always_ff @(posedge i_mclk) begin
    if (any_rst) begin
      cfg_view_reg <= 1'b0;
    end else if (cfg_fill_reg) begin
      cfg_view_reg <= 1'b1;
    end else if (buf_load) begin
      cfg_view_reg <= 1'b0;
    end
  end

  logic [7:0] reply_byte;
  always_comb begin
    reply_byte = buf_head; // [R22]
    if (cfg_view && buf_left == 4'h2) begin
      reply_byte = cfg_mem1;
    end else if (cfg_view && buf_left == 4'h1) begin
      reply_byte = cfg_mem2;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (i_rd) begin
      case (i_addr)
        REG_DATA_IN: begin
          if (state_reg == ST_REPLY && buf_left != 4'h0) begin
            rdata_next = reply_byte;
          end
        end
        REG_STATUS: rdata_next = status_word;
        REG_CONFIG: rdata_next = config_reg;
        REG_TMODE: rdata_next = {7'h00, tm_mode_reg};
        REG_TMASK: rdata_next = tm_mask_reg;
        REG_OPTION: rdata_next = option_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  assign o_rdata = rdata_reg;
  assign o_probe_req = probe_req_reg;
  assign o_probe = probe_reg;
  assign o_inq_installed = inq_reg;
  assign o_sel_respond = sel_reg;
  assign o_command_complete_flag = complete_reg;
  assign o_invalid_command_flag = invalid_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_probe_one_shot: assert property ( // [R1]
    @(posedge i_mclk) disable iff (i_rst)
    o_probe_req |=> !o_probe_req && state_reg == ST_SCAN_WAIT)
    else $error("probe request longer than one cycle");
  a_own_byte_zero: assert property ( // [R4]
    @(posedge i_mclk) disable iff (i_rst)
    (state_reg == ST_SCAN_ISSUE && own_hit) |-> buf_we && buf_wdata == 8'h00)
    else $error("own ID scan byte not zero");
  a_lun_bit_set: assert property ( // [R2]
    @(posedge i_mclk) disable iff (any_rst)
    (state_reg == ST_SCAN_WAIT && i_probe.done && lun_found && !last_lun)
    |=> scan_byte_reg[$past(probe_reg.lun)])
    else $error("found LUN not recorded");
  a_busy_retry: assert property ( // [R3]
    @(posedge i_mclk) disable iff (any_rst)
    (state_reg == ST_SCAN_WAIT && i_probe.done && may_retry)
    |=> state_reg == ST_SCAN_RETRY && o_probe == $past(o_probe))
    else $error("busy target not retried");
  a_done_on_drain: assert property ( // [R5]
    @(posedge i_mclk) disable iff (any_rst)
    (state_reg == ST_REPLY && last_pop) |=> o_command_complete_flag
    ##1 (o_command_complete_flag || $past(clr_complete)))
    else $error("complete flag missing after last byte");
  a_cfg_len_three: assert property ( // [R6]
    @(posedge i_mclk) disable iff (any_rst)
    (state_reg == ST_IDLE && wr_cmd && i_wdata == OP_CONFIG)
    |=> state_reg == ST_REPLY && buf_left == CFG_BYTES)
    else $error("config reply is not three bytes");
  a_bad_selector: assert property ( // [R10]
    @(posedge i_mclk) disable iff (any_rst)
    (state_reg == ST_PARM1 && wr_cmd && tm_feature && parm0_reg > SEL_TARGET)
    |=> o_invalid_command_flag && $stable(tm_mode_reg))
    else $error("bad selector not flagged");
  a_feature_off: assert property ( // [R14]
    @(posedge i_mclk) disable iff (any_rst)
    (state_reg == ST_PARM1 && wr_cmd && !tm_feature)
    |=> o_invalid_command_flag && !set_complete && $stable(tm_mode_reg))
    else $error("target mode accepted with feature off");
  a_leave_busy: assert property ( // [R15]
    @(posedge i_mclk) disable iff (any_rst)
    (state_reg == ST_PARM1 && wr_cmd && tm_feature && tm_mode_reg
     && i_tm_ccb_active && parm0_reg == SEL_INITIATOR)
    |=> tm_mode_reg && o_invalid_command_flag)
    else $error("left target mode with active blocks");
  a_reset_mode: assert property ( // [R18]
    @(posedge i_mclk) any_rst |=> !tm_mode_reg ##1 !o_sel_respond)
    else $error("reset did not disable target mode");
endmodule

// ==== scsi_probe_model.sv ====
// Behavioural population of SCSI targets that answers unit probes.
`timescale 1ns/100ps
module scsi_probe_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_req,
  input scsi_cfg_pkg::probe_req_s i_probe,
  input wire logic [63:0] i_map,
  input wire logic [2:0] i_busy_tgt,
  input wire logic [7:0] i_busy_cnt,
  output scsi_cfg_pkg::probe_rsp_s o_rsp
);
  import scsi_cfg_pkg::*;
  int wait_cnt;
  int busy_run;
  logic busy_now;
  assign busy_now = i_probe.tgt == i_busy_tgt && busy_run < int'(i_busy_cnt);
  always @(posedge i_mclk) begin
    o_rsp <= '{done: 1'b0, present: ~o_rsp.present, busy: ~o_rsp.busy};
    if (i_rst) begin
      wait_cnt <= 0;
      busy_run <= 0;
      o_rsp <= '0;
    end else if (i_req) begin
      wait_cnt <= $urandom_range(6, 1);
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end else if (wait_cnt == 1) begin
      wait_cnt <= 0;
      o_rsp.done <= 1'b1;
      o_rsp.present <= i_map[{i_probe.tgt, i_probe.lun}];
      o_rsp.busy <= busy_now;
      busy_run <= busy_now ? busy_run + 1 : 0;
    end
  end
endmodule

// ==== scsi_cfg_cmd_tb_top.sv ====
// Self-checking bench for the adapter query command block.
`timescale 1ns/100ps
module scsi_cfg_cmd_tb_top;
  import scsi_cfg_pkg::*;
  localparam int RC = 20;
  localparam int MR = 3;
  logic i_mclk, i_rst, i_wr, i_rd, i_tm_ccb_active, o_probe_req;
  logic o_inq_installed, o_sel_respond, o_command_complete_flag;
  logic o_invalid_command_flag, tm_on, opt;
  logic [2:0] i_addr, i_inq_lun, busy_tgt;
  logic [7:0] i_wdata, o_rdata, busy_cnt, d, cfg, tm_mask;
  logic [63:0] map;
  probe_req_s o_probe;
  probe_rsp_s rsp;
  int num_errors = 0, num_checks = 0, probes = 0, cyc = 1, busy_at = 0;
  int nbusy = 0;
  logic [7:0] dma_t [4] = '{8'h01, 8'h20, 8'h40, 8'h80};
  logic [7:0] irq_t [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h40};
  scsi_cfg_cmd #(.RETRY_CYC(RC), .MAX_RETRY(8'(MR))) i_scsi_cfg_cmd (
    .i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_probe_req, .o_probe, .i_probe(rsp), .i_tm_ccb_active, .i_inq_lun,
    .o_inq_installed, .o_sel_respond, .o_command_complete_flag,
    .o_invalid_command_flag);
  scsi_probe_model i_scsi_probe_model (.i_mclk, .i_rst, .i_req(o_probe_req),
    .i_probe(o_probe), .i_map(map), .i_busy_tgt(busy_tgt),
    .i_busy_cnt(busy_cnt), .o_rsp(rsp));
  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic hard_rst();
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    tm_on = 1'b0;
    tm_mask = 8'h00;
    opt = 1'b1;
  endtask
  task automatic reply(input logic [7:0] q [$]);
    foreach (q[k]) begin
      chk(o_command_complete_flag, 8'h00);
      rd(REG_DATA_IN, d);
      chk(d, q[k]);
    end
    @(posedge i_mclk) #1 chk(o_command_complete_flag, 8'h01);
    wr(REG_CTRL, 8'h03);
  endtask
  task automatic scan(input logic [7:0] bc);
    int p0;
    logic [7:0] q [$];
    busy_cnt = bc;
    p0 = probes;
    wr(REG_CMD, OP_SCAN);
    d = 8'h00;
    for (int n = 0; n < 2000 && !d[ST_DATA]; n++) rd(REG_STATUS, d);
    chk(8'(probes - p0), 8'(56 + 8 * (bc > MR ? MR : bc)));
    for (int t = 0; t < 8; t++)
      q.push_back((t == cfg[2:0] || (t == busy_tgt && bc > MR)) ?
        8'h00 : map[t*8 +: 8]);
    reply(q);
  endtask
  task automatic tm(input logic [7:0] s, input logic [7:0] m, input bit c);
    logic bad;
    bad = !opt || s > 8'h01 || (s == 8'h00 && tm_on && c);
    @(posedge i_mclk) i_tm_ccb_active <= c;
    wr(REG_CMD, OP_TMODE);
    wr(REG_CMD, s);
    wr(REG_CMD, m);
    @(posedge i_mclk) #1 chk(o_invalid_command_flag, 8'(bad));
    chk(o_command_complete_flag, 8'(!bad));
    if (!bad) tm_on = s[0];
    if (!bad && s[0]) tm_mask = m;
    chk(o_sel_respond, 8'(tm_on));
    rd(REG_TMODE, d);
    chk(d, 8'(tm_on));
    rd(REG_TMASK, d);
    chk(d, tm_mask);
    for (int k = 0; k < 8; k++) begin
      @(posedge i_mclk) i_inq_lun <= 3'(k);
      @(posedge i_mclk) #1 chk(o_inq_installed, 8'(tm_on & tm_mask[k]));
    end
    wr(REG_CTRL, 8'h03);
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (rsp.done) begin
      nbusy <= (rsp.busy && nbusy < MR) ? nbusy + 1 : 0;
      busy_at <= (rsp.busy && nbusy < MR) ? cyc : 0;
    end
    if (o_probe_req) begin
      probes <= probes + 1;
      busy_at <= 0;
      if (busy_at > 0)
        chk(8'(cyc - busy_at >= RC && cyc - busy_at <= RC + 6), 8'h01);
    end
  end
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (40000) @(posedge i_mclk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(80110));
    {i_rst, i_wr, i_rd, i_tm_ccb_active} = 4'h8;
    {i_addr, i_wdata, i_inq_lun, busy_cnt, busy_tgt, map} = '0;
    hard_rst();
    rd(REG_CONFIG, d);
    chk(d, 8'h07);
    rd(REG_OPTION, d);
    chk(d, 8'h01);
    repeat (3) begin
      cfg = {2'($urandom_range(3)), 3'($urandom_range(5)),
        3'($urandom_range(7))};
      wr(REG_CONFIG, cfg);
      wr(REG_CMD, OP_CONFIG);
      reply('{dma_t[cfg[7:6]], irq_t[cfg[5:3]], {5'h00, cfg[2:0]}});
    end
    wr(REG_CMD, 8'h5A);
    @(posedge i_mclk) #1 chk(o_invalid_command_flag, 8'h01);
    chk(o_command_complete_flag, 8'h00);
    rd(REG_STATUS, d);
    chk(d, 8'h02);
    wr(REG_CTRL, 8'h03);
    map = {$urandom, $urandom};
    busy_tgt = cfg[2:0] + 3'h1;
    map[{busy_tgt, 3'h0}] = 1'b1;
    scan(8'h02);
    scan(8'hC8);
    tm(8'h01, 8'($urandom_range(255, 1)), 1'b0);
    tm(8'($urandom_range(255, 2)), 8'h0F, 1'b0);
    tm(8'h00, 8'h00, 1'b1);
    tm(8'h00, 8'hFF, 1'b0);
    wr(REG_OPTION, 8'h00);
    opt = 1'b0;
    tm(8'h01, 8'h3C, 1'b0);
    wr(REG_OPTION, 8'h01);
    opt = 1'b1;
    tm(8'h01, 8'h81, 1'b0);
    wr(REG_CTRL, 8'h04);
    @(posedge i_mclk) #1 chk(o_sel_respond, 8'h00);
    tm_on = 1'b0;
    tm_mask = 8'h00;
    tm(8'h01, 8'h42, 1'b0);
    hard_rst();
    @(posedge i_mclk) #1 chk(o_sel_respond, 8'h00);
    tally_and_finish();
  end
endmodule
